// >>> rtl/pmic_config_decode_sequencer.sv
// Functional notes
// - Map 6-bit codes to millivolts: 50 mV steps wide rails, 25 mV bucks 2-4.
// - Codes below 001101 act as 001101 (1.200 V or 0.600 V).
// - Shift code 10 slows oscillator 16.5 percent, 11 speeds it, else none.
// - All timings count displaced oscillator ticks so they scale together.
// - Long-press timeout 2, 4, 8 or 16 s by code.
// - Acknowledge window 0.1, 0.5, 1 or 2 s by code.
// - Reset release delay 1 to 128 ms, doubling per code.
// - Soft-start step lasts 16, 32, 48 or 64 oscillator ticks.
// - Step assignment code decides the start-up step of each rail.
// - Code 00 rails start in the first step upon a start-up event.
// - Rails with participation clear are never switched on by the sequence.
// - Non-participating rails are ignored for step progress and reset release.
// - Rails on in hibernate with participation set stay on throughout start-up.
// - Per-rail turn-on delay 0 to 16 ms after previous step completes.
// - Code 01 is step 2; codes 10 and 11 are step 3.
`timescale 1ns/10ps
`default_nettype none
`include "pmic_seq_map.svh"
module pmic_config_decode_sequencer import pmic_seq_pkg::*; #(
	parameter int NUM_RAILS = `NUM_RAILS
) (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire rail_cfg_t             rail_cfg [NUM_RAILS],
	input  wire sys_cfg_t              sys_cfg,
	input  wire logic                  startup_event,
	input  wire logic                  from_hibernate,
	input  wire logic                  shutdown_req,
	output logic [NUM_RAILS-1:0]       rail_enable,
	output logic [NUM_RAILS-1:0]       rail_ramp_step,
	output logic [11:0]                rail_target_mv [NUM_RAILS],
	output logic [25:0]                long_press_ticks,
	output logic [22:0]                ack_window_ticks,
	output logic                       osc_tick_out,
	output logic                       system_reset_out_n,
	output logic                       sequence_done
);
	////////////////////////////////////////////////////////////////////////////
	// Decode functions.
	// Target voltage in mV from a code, with the low-code floor applied.
	function automatic logic [11:0] code_to_mv(input logic [5:0] code, input logic wide);
		logic [5:0] c;
		c = (code < `VCODE_FLOOR) ? 6'(`VCODE_FLOOR) : code;
		if (wide) begin
			code_to_mv = 12'(int'(c) * `WIDE_STEP_MV + 550);
		end else begin
			code_to_mv = 12'(int'(c) * `NARROW_STEP_MV + 275);
		end
	endfunction

	// Step delay in oscillator ticks: 0, 0.5, 1, 2, 4, 8, 12, 16 ms.
	function automatic logic [31:0] step_delay_ticks(input logic [2:0] sel);
		case (sel)
			3'h0: step_delay_ticks = 32'h0;
			3'h1: step_delay_ticks = 32'(`OSC_TICKS_HALF_MS);
			3'h2: step_delay_ticks = 32'(`OSC_TICKS_PER_MS);
			3'h3: step_delay_ticks = 32'(2 * `OSC_TICKS_PER_MS);
			3'h4: step_delay_ticks = 32'(4 * `OSC_TICKS_PER_MS);
			3'h5: step_delay_ticks = 32'(8 * `OSC_TICKS_PER_MS);
			3'h6: step_delay_ticks = 32'(12 * `OSC_TICKS_PER_MS);
			default: step_delay_ticks = 32'(16 * `OSC_TICKS_PER_MS);
		endcase
	endfunction

	// Step number 1..3 assigned to a rail.
	function automatic logic [1:0] step_of(input logic [1:0] sel);
		step_of = (sel == 2'h0) ? 2'h1 : (sel == 2'h1) ? 2'h2 : 2'h3;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Oscillator tick from the displaced divider.
	logic osc_tick;
	osc_tick_gen u_osc (
		.core_clk          (core_clk),
		.srst              (srst),
		.osc_freq_shift_sel(sys_cfg.osc_freq_shift_sel),
		.osc_tick          (osc_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state.
	seq_state_t                 state_reg, state_next;
	logic [NUM_RAILS-1:0]       en_reg, en_next;
	logic [NUM_RAILS-1:0]       armed_reg, armed_next;
	logic [NUM_RAILS-1:0]       ramp_reg, ramp_next;
	logic [31:0]                dly_reg [NUM_RAILS];
	logic [31:0]                dly_next [NUM_RAILS];
	logic [6:0]                 ss_reg [NUM_RAILS];
	logic [6:0]                 ss_next [NUM_RAILS];
	logic [31:0]                rst_cnt_reg, rst_cnt_next;
	logic                       rstn_reg, rstn_next;
	logic                       done_reg, done_next;
	logic [11:0]                mv_reg [NUM_RAILS];
	logic [11:0]                mv_next [NUM_RAILS];
	logic [25:0]                lp_reg, lp_next;
	logic [22:0]                aw_reg, aw_next;
	logic                       tick_reg;
	logic [1:0]                 cur_step;
	logic                       step_busy;

	// Next-state computation for sequencing, delays and decoded timings.
	always_comb begin
		state_next   = state_reg;
		en_next      = en_reg;
		armed_next   = armed_reg;
		ramp_next    = '0;
		rst_cnt_next = rst_cnt_reg;
		rstn_next    = rstn_reg;
		done_next    = done_reg;
		step_busy    = 1'b0;
		cur_step     = 2'(state_reg);
		for (int i = 0; i < NUM_RAILS; i++) begin
			dly_next[i] = dly_reg[i];
			ss_next[i]  = ss_reg[i];
			mv_next[i]  = code_to_mv(rail_cfg[i].rail_voltage_code, (i == 0) || (i >= `NUM_BUCKS));
		end
		lp_next = 26'(32'(2 * 1000 * `OSC_TICKS_PER_MS) << sys_cfg.long_press_timeout_sel);
		case (sys_cfg.press_ack_window_sel)
			2'h0: aw_next = 23'(100 * `OSC_TICKS_PER_MS);
			2'h1: aw_next = 23'(500 * `OSC_TICKS_PER_MS);
			2'h2: aw_next = 23'(1000 * `OSC_TICKS_PER_MS);
			default: aw_next = 23'(2000 * `OSC_TICKS_PER_MS);
		endcase
		case (state_reg)
			SEQ_IDLE: begin
				if (startup_event) begin
					for (int i = 0; i < NUM_RAILS; i++) begin
						// Rails on in hibernate and participating keep running.
						en_next[i] = from_hibernate && en_reg[i] &&
							rail_cfg[i].hib_on && rail_cfg[i].sequence_participate_en;
						armed_next[i] = 1'b0;
					end
					rstn_next = 1'b0;
					done_next = 1'b0;
					state_next = SEQ_STEP1;
				end
			end
			SEQ_STEP1, SEQ_STEP2, SEQ_STEP3: begin
				for (int i = 0; i < NUM_RAILS; i++) begin
					// Only participating rails of this step take part.
					if (rail_cfg[i].sequence_participate_en &&
						step_of(rail_cfg[i].startup_step_sel) == cur_step) begin
						if (!armed_reg[i]) begin
							armed_next[i] = 1'b1;
							dly_next[i] = step_delay_ticks(rail_cfg[i].step_delay_sel);
							ss_next[i]  = 7'(`SS_DIV_BASE * (int'(rail_cfg[i].soft_start_step_sel) + 1));
							step_busy = 1'b1;
						end else if (dly_reg[i] != 32'h0) begin
							step_busy = 1'b1;
							if (osc_tick) dly_next[i] = dly_reg[i] - 32'h1;
						end else if (!en_reg[i]) begin
							// Turn-on cycle holds the step so soft start runs before it advances.
							en_next[i] = 1'b1;
							step_busy = 1'b1;
						end else if (mv_reg[i] != 12'h0 && ss_reg[i] != 7'h0) begin
							// One soft-start step per full divider period.
							if (osc_tick) begin
								ss_next[i] = ss_reg[i] - 7'h01;
								if (ss_reg[i] == 7'h01) ramp_next[i] = 1'b1;
							end
							step_busy = 1'b1;
						end
					end
				end
				if (!step_busy) begin
					if (state_reg == SEQ_STEP3) begin
						state_next = SEQ_RSTD;
						rst_cnt_next = 32'(`OSC_TICKS_PER_MS) << sys_cfg.reset_release_delay_sel;
					end else begin
						state_next = seq_state_t'(3'(state_reg) + 3'h1);
					end
				end
			end
			SEQ_RSTD: begin
				if (rst_cnt_reg == 32'h0) begin
					rstn_next = 1'b1;
					done_next = 1'b1;
					state_next = SEQ_RUN;
				end else if (osc_tick) begin
					rst_cnt_next = rst_cnt_reg - 32'h1;
				end
			end
			SEQ_RUN: begin
				if (shutdown_req) state_next = SEQ_IDLE;
			end
			default: state_next = SEQ_IDLE;
		endcase
		if (shutdown_req && state_reg != SEQ_IDLE) begin
			// Hibernate entry keeps only rails flagged for hibernate.
			for (int i = 0; i < NUM_RAILS; i++) begin
				en_next[i] = en_reg[i] && from_hibernate && rail_cfg[i].hib_on;
			end
			rstn_next = 1'b0;
			done_next = 1'b0;
			state_next = SEQ_IDLE;
		end
	end

	// Registers of the sequencer.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg   <= SEQ_IDLE;
			en_reg      <= '0;
			armed_reg   <= '0;
			ramp_reg    <= '0;
			rst_cnt_reg <= 32'h0;
			rstn_reg    <= 1'b0;
			done_reg    <= 1'b0;
			lp_reg      <= 26'h0;
			aw_reg      <= 23'h0;
			tick_reg    <= 1'b0;
			for (int i = 0; i < NUM_RAILS; i++) begin
				dly_reg[i] <= 32'h0;
				ss_reg[i]  <= 7'h00;
				mv_reg[i]  <= 12'h000;
			end
		end else begin
			state_reg   <= state_next;
			en_reg      <= en_next;
			armed_reg   <= armed_next;
			ramp_reg    <= ramp_next;
			rst_cnt_reg <= rst_cnt_next;
			rstn_reg    <= rstn_next;
			done_reg    <= done_next;
			lp_reg      <= lp_next;
			aw_reg      <= aw_next;
			tick_reg    <= osc_tick;
			for (int i = 0; i < NUM_RAILS; i++) begin
				dly_reg[i] <= dly_next[i];
				ss_reg[i]  <= ss_next[i];
				mv_reg[i]  <= mv_next[i];
			end
		end
	end

	// Outputs straight from registers.
	assign rail_enable        = en_reg;
	assign rail_ramp_step     = ramp_reg;
	assign rail_target_mv     = mv_reg;
	assign long_press_ticks   = lp_reg;
	assign ack_window_ticks   = aw_reg;
	assign osc_tick_out       = tick_reg;
	assign system_reset_out_n = rstn_reg;
	assign sequence_done      = done_reg;
endmodule
`default_nettype wire

// >>> rtl/pmic_seq_map.svh
`ifndef PMIC_SEQ_MAP_SVH
`define PMIC_SEQ_MAP_SVH
// Clock rates in kHz.
`define CORE_CLK_KHZ        100000
`define OSC_NOM_KHZ         2000
// Oscillator displacement in tenths of a percent.
`define OSC_SHIFT_PERMILLE  165
// Core cycles per nominal oscillator tick, and the displaced variants.
`define OSC_DIV_NOM         (`CORE_CLK_KHZ / `OSC_NOM_KHZ)
`define OSC_DIV_SLOW        ((`OSC_DIV_NOM * 1000 + (1000 - `OSC_SHIFT_PERMILLE) - 1) / (1000 - `OSC_SHIFT_PERMILLE))
`define OSC_DIV_FAST        ((`OSC_DIV_NOM * 1000) / (1000 + `OSC_SHIFT_PERMILLE))
// Frequency shift codes.
`define FSD_SLOW            2'h2
`define FSD_FAST            2'h3
// Oscillator ticks per millisecond and per half millisecond.
`define OSC_TICKS_PER_MS    2000
`define OSC_TICKS_HALF_MS   1000
// Soft-start divider base in oscillator ticks.
`define SS_DIV_BASE         16
// Voltage code floor and step sizes in millivolts.
`define VCODE_FLOOR         6'h0D
`define WIDE_STEP_MV        50
`define NARROW_STEP_MV      25
// Number of rails: four bucks then two linear rails.
`define NUM_RAILS           6
`define NUM_BUCKS           4
`endif

// >>> rtl/pmic_seq_pkg.sv
package pmic_seq_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b000,
		SEQ_STEP1 = 3'b001,
		SEQ_STEP2 = 3'b010,
		SEQ_STEP3 = 3'b011,
		SEQ_RSTD  = 3'b100,
		SEQ_RUN   = 3'b101
	} seq_state_t;
	// Per-rail configuration group.
	typedef struct packed {
		logic [5:0] rail_voltage_code;
		logic [1:0] soft_start_step_sel;
		logic [1:0] startup_step_sel;
		logic [2:0] step_delay_sel;
		logic       sequence_participate_en;
		logic       hib_on;
	} rail_cfg_t;
	// System timing group.
	typedef struct packed {
		logic [1:0] osc_freq_shift_sel;
		logic [1:0] long_press_timeout_sel;
		logic [1:0] press_ack_window_sel;
		logic [2:0] reset_release_delay_sel;
	} sys_cfg_t;
endpackage

// >>> rtl/osc_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmic_seq_map.svh"
// Displaced internal oscillator: one enable pulse per oscillator period.
module osc_tick_gen import pmic_seq_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic [1:0] osc_freq_shift_sel,
	output logic            osc_tick
);
	logic [7:0] div_reg;
	logic [7:0] div_next;
	logic [7:0] div_max;
	logic       tick_reg;
	logic       tick_next;

	// Period chosen from the shift code; 00 and 01 both give nominal.
	always_comb begin
		if (osc_freq_shift_sel == `FSD_SLOW) begin
			div_max = 8'(`OSC_DIV_SLOW - 1);
		end else if (osc_freq_shift_sel == `FSD_FAST) begin
			div_max = 8'(`OSC_DIV_FAST - 1);
		end else begin
			div_max = 8'(`OSC_DIV_NOM - 1);
		end
		tick_next = (div_reg >= div_max);
		div_next  = tick_next ? 8'h00 : div_reg + 8'h01;
	end

	// Divider registers.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_reg  <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign osc_tick = tick_reg;
endmodule
`default_nettype wire

// >>> tb/pmic_seq_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmic_seq_map.svh"
module pmic_seq_checker import pmic_seq_pkg::*; #(
	parameter int NUM_RAILS = 6
) (
	input wire logic                 core_clk,
	input wire logic                 srst,
	input wire rail_cfg_t            rail_cfg [NUM_RAILS],
	input wire sys_cfg_t             sys_cfg,
	input wire logic [NUM_RAILS-1:0] rail_enable,
	input wire logic [11:0]          rail_target_mv [NUM_RAILS],
	input wire logic [25:0]          long_press_ticks,
	input wire logic [22:0]          ack_window_ticks,
	input wire logic                 osc_tick_out,
	input wire logic                 system_reset_out_n,
	input wire logic                 sequence_done
);
	logic [NUM_RAILS-1:0] part;
	logic [7:0]           gap_reg, gap_next;
	logic [1:0]           shift_reg;
	logic                 steady_reg, steady_next;

	function automatic logic [11:0] mv_of(input logic [5:0] c, input logic wide);
		logic [11:0] f;
		f = (c < 6'h0D) ? 12'h00D : {6'h00, c};
		return wide ? 12'h226 + 12'h032 * f : 12'h113 + 12'h019 * f;
	endfunction
	function automatic logic [22:0] ack_of(input logic [1:0] s);
		case (s)
			2'h0: return 23'h030D40;
			2'h1: return 23'h0F4240;
			2'h2: return 23'h1E8480;
			default: return 23'h3D0900;
		endcase
	endfunction
	function automatic logic [7:0] gap_of(input logic [1:0] s);
		if (s == `FSD_SLOW) return 8'(`OSC_DIV_SLOW);
		if (s == `FSD_FAST) return 8'(`OSC_DIV_FAST);
		return 8'(`OSC_DIV_NOM);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// A tick interval only counts as steady if the shift code held across all of it.
	always_comb begin
		for (int i = 0; i < NUM_RAILS; i++) part[i] = rail_cfg[i].sequence_participate_en;
		gap_next = osc_tick_out ? 8'h01 : gap_reg + 8'h01;
		steady_next = (osc_tick_out | steady_reg) & (sys_cfg.osc_freq_shift_sel == shift_reg);
	end
	// Registers the tick tracker.
	always_ff @(posedge core_clk) begin
		shift_reg  <= sys_cfg.osc_freq_shift_sel;
		gap_reg    <= gap_next;
		steady_reg <= srst ? 1'b0 : steady_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (srst);

	a_part_gates_rail: assert property ((rail_enable & ~part) == '0)
		else $error("Rail on without participation");
	a_release_done: assert property ($rose(system_reset_out_n) |-> sequence_done)
		else $error("Reset released without done");
	a_target_wide: assert property (!$past(srst) |=>
		rail_target_mv[0] == mv_of($past(rail_cfg[0].rail_voltage_code), 1'b1))
		else $error("Wide rail target wrong");
	a_target_narrow: assert property (!$past(srst) |=>
		rail_target_mv[1] == mv_of($past(rail_cfg[1].rail_voltage_code), 1'b0))
		else $error("Narrow rail target wrong");
	a_press_timeout: assert property (!$past(srst) |=>
		long_press_ticks == 26'h3D0900 << $past(sys_cfg.long_press_timeout_sel))
		else $error("Long press timeout wrong");
	a_ack_window: assert property (!$past(srst) |=>
		ack_window_ticks == ack_of($past(sys_cfg.press_ack_window_sel)))
		else $error("Acknowledge window wrong");
	a_osc_spacing: assert property (osc_tick_out && steady_reg |-> gap_reg == gap_of(shift_reg))
		else $error("Oscillator tick spacing wrong");
	a_done_all_rails: assert property (sequence_done |-> (rail_enable | ~part) == '1)
		else $error("Done with a participating rail off");

	c_release: cover property ($rose(system_reset_out_n));
	c_fast_tick: cover property (osc_tick_out && steady_reg && shift_reg == `FSD_FAST);
	c_step2: cover property ($rose(rail_enable[1]));
endmodule

bind pmic_config_decode_sequencer pmic_seq_checker #(.NUM_RAILS(NUM_RAILS)) pmic_seq_checker_inst (
	.core_clk(core_clk), .srst(srst), .rail_cfg(rail_cfg), .sys_cfg(sys_cfg),
	.rail_enable(rail_enable), .rail_target_mv(rail_target_mv),
	.long_press_ticks(long_press_ticks), .ack_window_ticks(ack_window_ticks),
	.osc_tick_out(osc_tick_out), .system_reset_out_n(system_reset_out_n),
	.sequence_done(sequence_done)
);
`default_nettype wire

// >>> tb/pmic_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmic_host_model (
	input  wire logic core_clk,
	output logic      startup_event,
	output logic      shutdown_req
);
	// Both power-control pins rest low.
	initial begin
		startup_event = 1'b0;
		shutdown_req = 1'b0;
	end
	// Raises the start-up event for one cycle, launched after a falling edge.
	task automatic start_pulse();
		@(negedge core_clk);
		startup_event = 1'b1;
		@(negedge core_clk);
		startup_event = 1'b0;
	endtask
	// Raises the shutdown request for one cycle.
	task automatic stop_pulse();
		@(negedge core_clk);
		shutdown_req = 1'b1;
		@(negedge core_clk);
		shutdown_req = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/pmic_config_decode_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pmic_config_decode_sequencer_bench import pmic_seq_pkg::*;;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        from_hibernate = 1'b0;
	logic        startup_event, shutdown_req, osc_tick_out, system_reset_out_n, sequence_done;
	logic [5:0]  rail_enable;
	logic [5:0]  rail_ramp_step;
	logic [11:0] rail_target_mv [6];
	logic [25:0] long_press_ticks;
	logic [22:0] ack_window_ticks;
	rail_cfg_t   rail_cfg [6];
	sys_cfg_t    sys_cfg = '0;
	int          err_total = 0;
	int          checked = 0;
	int          ramp_count = 0;

	// Core clock at 100 MHz.
	always #5 core_clk = ~core_clk;

	// Counts soft-start completion pulses of the first buck rail.
	always @(negedge core_clk) begin
		if (rail_ramp_step[0] === 1'b1) ramp_count++;
	end

	pmic_config_decode_sequencer pmic_config_decode_sequencer_inst (
		.core_clk(core_clk), .srst(srst), .rail_cfg(rail_cfg), .sys_cfg(sys_cfg),
		.startup_event(startup_event), .from_hibernate(from_hibernate),
		.shutdown_req(shutdown_req), .rail_enable(rail_enable),
		.rail_ramp_step(rail_ramp_step),
		.rail_target_mv(rail_target_mv), .long_press_ticks(long_press_ticks),
		.ack_window_ticks(ack_window_ticks), .osc_tick_out(osc_tick_out),
		.system_reset_out_n(system_reset_out_n), .sequence_done(sequence_done)
	);
	pmic_host_model pmic_host_model_inst (
		.core_clk(core_clk), .startup_event(startup_event), .shutdown_req(shutdown_req)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] exp_mv(input logic [5:0] c, input logic wide);
		logic [11:0] f;
		f = (c < 6'h0D) ? 12'h00D : {6'h00, c};
		return wide ? 12'h226 + 12'h032 * f : 12'h113 + 12'h019 * f;
	endfunction
	// Compares a design value exactly.
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// Compares a measured cycle count against a window.
	task automatic cmp_span(input string what, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask
	// Counts falling edges until a rail turns on, up to a limit.
	task automatic wait_on(input int idx, input int lim, output int n);
		for (n = 0; n < lim && rail_enable[idx] !== 1'b1; n++) @(negedge core_clk);
	endtask
	// Measures the cycles between two oscillator ticks.
	task automatic tick_gap(output int n);
		for (int i = 0; i < 200 && osc_tick_out !== 1'b1; i++) @(negedge core_clk);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (osc_tick_out !== 1'b1 && n < 200);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("Checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Cuts a hang short a few thousand cycles past the expected end of the tests.
	initial begin
		#970000;
		err_total++;
		complete_run();
	end
	// Decode tables, oscillator periods, then two start-up sequences.
	initial begin
		int n, t2;
		logic drop;
		static logic [5:0] codes [6] = '{6'h00, 6'h0C, 6'h0D, 6'h0E, 6'h25, 6'h3F};
		static logic [22:0] acks [4] = '{23'h030D40, 23'h0F4240, 23'h1E8480, 23'h3D0900};
		static int gaps [4] = '{50, 50, 60, 42};
		static logic [1:0] steps [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
		foreach (rail_cfg[i]) rail_cfg[i] = '0;
		repeat (12) @(negedge core_clk);
		srst = 1'b0;
		foreach (codes[k]) begin
			foreach (rail_cfg[i]) rail_cfg[i].rail_voltage_code = codes[k];
			repeat (2) @(negedge core_clk);
			cmp_val("wide mv", exp_mv(codes[k], 1'b1), rail_target_mv[0]);
			cmp_val("narrow mv", exp_mv(codes[k], 1'b0), rail_target_mv[2]);
			cmp_val("linear mv", exp_mv(codes[k], 1'b1), rail_target_mv[5]);
		end
		for (int s = 0; s < 4; s++) begin
			sys_cfg.long_press_timeout_sel = s[1:0];
			sys_cfg.press_ack_window_sel = s[1:0];
			repeat (2) @(negedge core_clk);
			cmp_val("press ticks", 26'h3D0900 << s, long_press_ticks);
			cmp_val("ack ticks", acks[s], ack_window_ticks);
		end
		for (int s = 0; s < 4; s++) begin
			sys_cfg.osc_freq_shift_sel = s[1:0];
			tick_gap(n);
			tick_gap(n);
			cmp_val("osc gap", gaps[s], n);
		end
		foreach (rail_cfg[i]) begin
			rail_cfg[i].startup_step_sel = steps[i];
			rail_cfg[i].sequence_participate_en = i inside {0, 1, 2, 4};
			rail_cfg[i].hib_on = i >= 4;
		end
		rail_cfg[0].soft_start_step_sel = 2'h3;
		pmic_host_model_inst.start_pulse();
		wait_on(0, 200, n);
		cmp_span("step1 on", 0, 199, n);
		wait_on(1, 4000, n);
		cmp_span("step2 delay", 63 * 42, 67 * 42, n);
		cmp_val("ramp pulses", 1, ramp_count);
		cmp_val("step3 early", 1'b0, rail_enable[2]);
		wait_on(4, 2000, n);
		cmp_span("step3 on", 0, 1999, n);
		from_hibernate = 1'b1;
		pmic_host_model_inst.stop_pulse();
		repeat (3) @(negedge core_clk);
		cmp_val("hib rails", 6'b010000, rail_enable);
		pmic_host_model_inst.start_pulse();
		t2 = -1;
		drop = 1'b0;
		for (n = 0; n < 95000 && system_reset_out_n !== 1'b1; n++) begin
			@(negedge core_clk);
			if (rail_enable[4] !== 1'b1) drop = 1'b1;
			if (t2 < 0 && rail_enable[2] === 1'b1) t2 = n;
		end
		cmp_span("release delay", 2014 * 42, 2020 * 42, n - t2);
		cmp_val("hib rail drop", 1'b0, drop);
		cmp_val("final rails", 6'b010111, rail_enable);
		cmp_val("done", 1'b1, sequence_done);
		cmp_val("ramp total", 2, ramp_count);
		complete_run();
	end
endmodule
`default_nettype wire
